// File: rtl/uart_rx_pkg.sv
// Purpose: shared constants of the uart receive status block
// Assumes: mclk at 250 MHz, sampling clock at 16x the baud rate
// Notes: timing counts derive from times in ns
package uart_rx_pkg;
  localparam int CLK_PERIOD_NS = 4;
  localparam int DATA_MAX_BITS = 9;
  localparam int ERR_BITS = 2;
  localparam int WORD_BITS = DATA_MAX_BITS + ERR_BITS;
  localparam int FRAMING_ERROR_FLAG_POS = 9;
  localparam int PARITY_ERROR_FLAG_POS = 10;
  localparam int FIFO_DEPTH = 4;
  localparam int SYNC_STAGES = 2;
  localparam logic [3:0] PHASE_SAMPLE = 4'h9;
  localparam logic [3:0] PHASE_LAST = 4'hf;
  localparam logic [3:0] DATA_BITS_EIGHT = 4'h8;
  localparam logic [3:0] DATA_BITS_NINE = 4'h9;
  localparam int WAKE_IGNORE_NS = 2000;
  localparam int WAKE_IGNORE_CYCLES = (WAKE_IGNORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IRQ_PULSE_NS = 64;
  localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_NS / CLK_PERIOD_NS;
  localparam logic [DATA_MAX_BITS-1:0] WORD_RESET = 9'h000;
endpackage

// File: rtl/uart_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: inputs come from outside the mclk domain
// Notes: only the second stage is visible
`timescale 1ns/1ps
module uart_sync #(
  parameter int WIDTH = 2
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // levels
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stageOne_reg;

  initial begin
    if (WIDTH < 1) $error("uart_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      stageOne_reg <= '1;
      syncOut <= '1;
    end else begin
      stageOne_reg <= asyncIn;
      syncOut <= stageOne_reg;
    end
  end
endmodule

// File: rtl/uart_rx_fifo.sv
// Purpose: receive word buffer with valid and ready on both sides
// Assumes: depth is a power of two
// Notes: head word is shown while outValid is high
`timescale 1ns/1ps
module uart_rx_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  // fill level
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr_reg;
  logic [AW-1:0] rdPtr_reg;
  logic [AW:0] count_reg;
  logic doPush;
  logic doPop;

  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("uart_rx_fifo: DEPTH must be a power of two");
  end

  assign inReady = count_reg != (AW+1)'(DEPTH);
  assign outValid = count_reg != '0;
  assign outData = mem[rdPtr_reg];
  assign level = count_reg;
  assign doPush = inValid && inReady;
  assign doPop = outValid && outReady;

  always_ff @(posedge mclk) begin
    if (doPush) begin
      mem[wrPtr_reg] <= inData;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (doPush) wrPtr_reg <= wrPtr_reg + 1'b1;
      if (doPop) rdPtr_reg <= rdPtr_reg + 1'b1;
      if (doPush && !doPop) count_reg <= count_reg + 1'b1;
      else if (doPop && !doPush) count_reg <= count_reg - 1'b1;
    end
  end
endmodule

// File: rtl/uart_rx_status.sv
// Purpose: uart receiver with status flags, host interrupt and power control
// Assumes: bitClk runs at 16x baud; host strobes are one-cycle mclk pulses
// Notes: What this block does is listed below
`timescale 1ns/1ps
module uart_rx_status #(
  parameter int FIFO_DEPTH = uart_rx_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // link pins
  input wire logic rxPin,
  input wire logic bitClk,
  output logic txForceHigh,
  // configuration
  input wire logic modulePowerEnable,
  input wire logic receiverEnableBit,
  input wire logic receiveIrqEnable,
  input wire logic parityEnable,
  input wire logic parityOdd,
  input wire logic twoStopBits,
  input wire logic nineBitSelect,
  input wire logic addressDetectEnable,
  input wire logic wakeEnable,
  input wire logic txEmptyIrqEnable,
  input wire logic txIdleIrqEnable,
  // transmitter conditions
  input wire logic txEmptyFlag,
  input wire logic txIdleFlag,
  // host strobes
  input wire logic statusAccess,
  input wire logic fifoRead,
  // status
  output logic receiverIdleFlag,
  output logic receiveDataFlag,
  output logic overrunFlag,
  output logic noiseFlag,
  output logic framingErrorFlag,
  output logic parityErrorFlag,
  output logic [uart_rx_pkg::DATA_MAX_BITS-1:0] rxWord,
  output logic rxWordValid,
  // host interrupt and wake
  output logic hostIrq_b,
  output logic wakeUp
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_START = 3'b001,
    ST_DATA = 3'b010,
    ST_PARITY = 3'b011,
    ST_STOP = 3'b100,
    ST_WAIT_HIGH = 3'b101
  } rx_state_t;

  localparam int WB = uart_rx_pkg::WORD_BITS;
  localparam int LW = $clog2(FIFO_DEPTH) + 1;
  localparam logic [9:0] WAKE_CNT = 10'(uart_rx_pkg::WAKE_IGNORE_CYCLES);
  localparam logic [4:0] IRQ_CNT = 5'(uart_rx_pkg::IRQ_PULSE_CYCLES);

  initial begin
    if (FIFO_DEPTH < 2) $error("uart_rx_status: FIFO_DEPTH too small");
  end

  logic [1:0] syncOut;
  logic rxLine;
  logic bitClkS;
  logic bitClkPrev_reg;
  logic tick;
  logic rxPrev_reg;
  rx_state_t state_reg;
  logic [3:0] phase_reg;
  logic [3:0] bitIdx_reg;
  logic stopIdx_reg;
  logic [2:0] window_reg;
  logic bitVal;
  logic bitNoisy;
  logic sampleNow;
  logic bitEnd;
  logic [uart_rx_pkg::DATA_MAX_BITS-1:0] shift_reg;
  logic parityAcc_reg;
  logic frameNoise_reg;
  logic frameFerr_reg;
  logic framePerr_reg;
  logic [3:0] dataBits;
  logic frameDone;
  logic [WB-1:0] doneWord;
  logic [uart_rx_pkg::DATA_MAX_BITS-1:0] doneData;
  logic doneFerr;
  logic fifoInReady;
  logic fifoOutValid;
  logic [WB-1:0] fifoOutData;
  logic [LW-1:0] fifoLevel;
  logic pushWord;
  logic overrunEvent;
  logic popWord;
  logic clearSeq;
  logic armed_reg;
  logic rxRun;
  logic wakeArmed_reg;
  logic [9:0] ignore_reg;
  logic wakeEvent;
  logic txEmptyPrev_reg;
  logic txIdlePrev_reg;
  logic irqEvent;
  logic [4:0] irqCnt_reg;
  logic topBit;

  uart_sync #(.WIDTH(uart_rx_pkg::SYNC_STAGES)) u_sync (
    .mclk(mclk),
    .rst_b(rst_b),
    .asyncIn({bitClk, rxPin}),
    .syncOut(syncOut)
  );
  assign rxLine = syncOut[0];
  assign bitClkS = syncOut[1];
  assign tick = bitClkS && !bitClkPrev_reg;

  // receiver runs only powered, enabled and past the ignore interval that follows a wake event
  assign rxRun = modulePowerEnable && receiverEnableBit && (ignore_reg == '0);
  assign sampleNow = tick && (phase_reg == uart_rx_pkg::PHASE_SAMPLE);
  assign bitEnd = tick && (phase_reg == uart_rx_pkg::PHASE_LAST);
  // majority of three oversamples; disagreement marks noise
  assign bitVal = (window_reg[0] & window_reg[1]) | (window_reg[1] & window_reg[2]) |
                  (window_reg[0] & window_reg[2]);
  assign bitNoisy = !(&window_reg) && (|window_reg);
  assign dataBits = nineBitSelect ? uart_rx_pkg::DATA_BITS_NINE : uart_rx_pkg::DATA_BITS_EIGHT;
  assign frameDone = (state_reg == ST_STOP) && sampleNow && (stopIdx_reg == twoStopBits);
  assign doneFerr = frameFerr_reg || !bitVal;
  assign doneData = nineBitSelect ? shift_reg : {1'b0, shift_reg[8:1]};
  assign doneWord = {framePerr_reg, doneFerr, doneData};

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      bitClkPrev_reg <= 1'b1;
      rxPrev_reg <= 1'b1;
    end else begin
      bitClkPrev_reg <= bitClkS;
      rxPrev_reg <= rxLine;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      bitIdx_reg <= '0;
      stopIdx_reg <= 1'b0;
      window_reg <= 3'h7;
    end else if (!rxRun) begin
      state_reg <= ST_IDLE;
      phase_reg <= '0;
      window_reg <= 3'h7;
    end else if (tick) begin
      window_reg <= {window_reg[1:0], rxLine};
      phase_reg <= phase_reg + 1'b1;
      unique case (state_reg)
        ST_IDLE: begin
          phase_reg <= '0;
          if (!rxLine) begin
            state_reg <= ST_START;
            phase_reg <= 4'h1;
          end
        end
        ST_START: begin
          if (sampleNow && bitVal) state_reg <= ST_IDLE;
          else if (bitEnd) begin
            state_reg <= ST_DATA;
            bitIdx_reg <= '0;
          end
        end
        ST_DATA: begin
          if (bitEnd) begin
            bitIdx_reg <= bitIdx_reg + 1'b1;
            if (bitIdx_reg == dataBits - 4'h1) begin
              state_reg <= parityEnable ? ST_PARITY : ST_STOP;
              stopIdx_reg <= 1'b0;
            end
          end
        end
        ST_PARITY: begin
          if (bitEnd) begin
            state_reg <= ST_STOP;
            stopIdx_reg <= 1'b0;
          end
        end
        ST_STOP: begin
          if (frameDone) begin
            state_reg <= doneFerr ? ST_WAIT_HIGH : ST_IDLE;
            phase_reg <= '0;
          end else if (bitEnd) begin
            stopIdx_reg <= 1'b1;
          end
        end
        ST_WAIT_HIGH: begin
          phase_reg <= '0;
          if (rxLine) state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // frame content and its per-frame error marks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_reg <= uart_rx_pkg::WORD_RESET;
      parityAcc_reg <= 1'b0;
      frameNoise_reg <= 1'b0;
      frameFerr_reg <= 1'b0;
      framePerr_reg <= 1'b0;
    end else if (state_reg == ST_IDLE) begin
      parityAcc_reg <= 1'b0;
      frameNoise_reg <= 1'b0;
      frameFerr_reg <= 1'b0;
      framePerr_reg <= 1'b0;
    end else if (sampleNow) begin
      if (bitNoisy) frameNoise_reg <= 1'b1;
      if (state_reg == ST_DATA) begin
        shift_reg <= {bitVal, shift_reg[8:1]};
        parityAcc_reg <= parityAcc_reg ^ bitVal;
      end
      if (state_reg == ST_PARITY) framePerr_reg <= (parityAcc_reg ^ bitVal) != parityOdd;
      if (state_reg == ST_STOP && !bitVal) frameFerr_reg <= 1'b1;
    end
  end

  // receiver idle between stop sample and next start detect
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) receiverIdleFlag <= 1'b1;
    else if (frameDone || (rxRun && sampleNow && state_reg == ST_START && bitVal)) receiverIdleFlag <= 1'b1;
    else if (tick && rxRun && state_reg == ST_IDLE && !rxLine) receiverIdleFlag <= 1'b0;
  end

  assign pushWord = frameDone && fifoInReady;
  assign overrunEvent = frameDone && !fifoInReady;
  assign popWord = fifoRead && fifoOutValid;
  assign clearSeq = fifoRead && armed_reg;

  uart_rx_fifo #(.WIDTH(WB), .DEPTH(FIFO_DEPTH)) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .inValid(frameDone),
    .inReady(fifoInReady),
    .inData(doneWord),
    .outValid(fifoOutValid),
    .outReady(fifoRead),
    .outData(fifoOutData),
    .level(fifoLevel)
  );

  // clear sequence: a status access arms, the next buffer read clears
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) armed_reg <= 1'b0;
    else if (statusAccess) armed_reg <= 1'b1;
    else if (fifoRead) armed_reg <= 1'b0;
  end

  // sticky flags; a set in the clearing cycle wins
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      receiveDataFlag <= 1'b0;
      overrunFlag <= 1'b0;
      noiseFlag <= 1'b0;
    end else begin
      if (pushWord) receiveDataFlag <= 1'b1;
      else if (clearSeq && (!popWord || fifoLevel == LW'(1))) receiveDataFlag <= 1'b0;
      if (overrunEvent) overrunFlag <= 1'b1;
      else if (clearSeq) overrunFlag <= 1'b0;
      if (pushWord && frameNoise_reg) noiseFlag <= 1'b1;
      else if (clearSeq) noiseFlag <= 1'b0;
    end
  end

  // head of buffer with its stored error marks
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rxWord <= uart_rx_pkg::WORD_RESET;
      rxWordValid <= 1'b0;
      framingErrorFlag <= 1'b0;
      parityErrorFlag <= 1'b0;
    end else begin
      rxWord <= fifoOutData[uart_rx_pkg::DATA_MAX_BITS-1:0];
      rxWordValid <= fifoOutValid;
      framingErrorFlag <= fifoOutValid && fifoOutData[uart_rx_pkg::FRAMING_ERROR_FLAG_POS];
      parityErrorFlag <= fifoOutValid && fifoOutData[uart_rx_pkg::PARITY_ERROR_FLAG_POS];
    end
  end

  // wake arming is captured while powered; flags and configuration untouched
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) wakeArmed_reg <= 1'b0;
    else if (modulePowerEnable) wakeArmed_reg <= wakeEnable && receiverEnableBit && receiveIrqEnable;
    else if (wakeEvent) wakeArmed_reg <= 1'b0;
  end

  assign wakeEvent = !modulePowerEnable && wakeArmed_reg && rxPrev_reg && !rxLine;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wakeUp <= 1'b0;
      ignore_reg <= '0;
      txForceHigh <= 1'b1;
    end else begin
      wakeUp <= wakeEvent;
      txForceHigh <= !modulePowerEnable;
      if (wakeEvent) ignore_reg <= WAKE_CNT;
      else if (ignore_reg != '0) ignore_reg <= ignore_reg - 1'b1;
    end
  end

  // interrupt sources and address qualifier
  assign topBit = nineBitSelect ? doneData[8] : doneData[7];
  assign irqEvent = (receiveIrqEnable && pushWord && (!addressDetectEnable || topBit)) ||
                    (receiveIrqEnable && overrunEvent) ||
                    (txEmptyIrqEnable && txEmptyFlag && !txEmptyPrev_reg) ||
                    (txIdleIrqEnable && txIdleFlag && !txIdlePrev_reg) ||
                    wakeEvent;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      txEmptyPrev_reg <= 1'b0;
      txIdlePrev_reg <= 1'b0;
      irqCnt_reg <= '0;
      hostIrq_b <= 1'b1;
    end else begin
      txEmptyPrev_reg <= txEmptyFlag;
      txIdlePrev_reg <= txIdleFlag;
      if (irqEvent) irqCnt_reg <= IRQ_CNT;
      else if (irqCnt_reg != '0) irqCnt_reg <= irqCnt_reg - 1'b1;
      hostIrq_b <= !(irqEvent || irqCnt_reg > 5'h1);
    end
  end
endmodule

// File: testbench/uart_rx_status_chk.sv
// Purpose: port assertions for the uart receive status block
// Assumes: one clock domain, mclk
// Notes: bound to every uart_rx_status instance
`timescale 1ns/1ps
module uart_rx_status_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // inputs watched
  input wire logic modulePowerEnable,
  input wire logic receiveIrqEnable,
  input wire logic addressDetectEnable,
  input wire logic txEmptyIrqEnable,
  input wire logic txEmptyFlag,
  input wire logic fifoRead,
  // outputs watched
  input wire logic txForceHigh,
  input wire logic receiverIdleFlag,
  input wire logic receiveDataFlag,
  input wire logic overrunFlag,
  input wire logic noiseFlag,
  input wire logic framingErrorFlag,
  input wire logic parityErrorFlag,
  input wire logic rxWordValid,
  input wire logic hostIrq_b,
  input wire logic wakeUp
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  irq_pulse_a: assert property ($fell(hostIrq_b) |-> (!hostIrq_b)[*8] ##1 (!hostIrq_b)[*8])
    else $error("interrupt pulse too short");
  rx_irq_a: assert property (
    $rose(receiveDataFlag) && receiveIrqEnable && !addressDetectEnable |-> ##[0:2] !hostIrq_b)
    else $error("no interrupt for stored word");
  tx_irq_a: assert property ($rose(txEmptyFlag) && txEmptyIrqEnable |-> ##[0:3] !hostIrq_b)
    else $error("no interrupt for transmit empty");
  tx_high_a: assert property (!modulePowerEnable && !$past(modulePowerEnable) |-> txForceHigh)
    else $error("transmit pin not forced high");
  wake_pulse_a: assert property (wakeUp |=> !wakeUp)
    else $error("wake pulse longer than one cycle");
  wake_irq_a: assert property (wakeUp |-> ##[0:2] !hostIrq_b)
    else $error("no interrupt on wake");
  ovr_clear_a: assert property ($fell(overrunFlag) |-> $past(fifoRead))
    else $error("overrun flag fell without buffer read");
  noise_clear_a: assert property ($fell(noiseFlag) |-> $past(fifoRead))
    else $error("noise flag fell without buffer read");
  data_clear_a: assert property ($fell(receiveDataFlag) |-> $past(fifoRead))
    else $error("data flag fell without buffer read");
  idle_push_a: assert property ($rose(rxWordValid) |-> receiverIdleFlag)
    else $error("idle flag low at word store");
  data_flag_a: assert property ($rose(rxWordValid) |-> ##[0:2] receiveDataFlag)
    else $error("data flag not set for stored word");
  noise_data_a: assert property ($rose(noiseFlag) |-> ##[0:1] receiveDataFlag)
    else $error("noise flag without data flag");
  empty_marks_a: assert property (
    !rxWordValid && !$past(rxWordValid) && !$past(rxWordValid, 2) |-> !framingErrorFlag && !parityErrorFlag)
    else $error("error marks shown with empty buffer");
endmodule
bind uart_rx_status uart_rx_status_chk chk (.mclk, .rst_b, .modulePowerEnable, .receiveIrqEnable,
  .addressDetectEnable, .txEmptyIrqEnable, .txEmptyFlag, .fifoRead, .txForceHigh, .receiverIdleFlag,
  .receiveDataFlag, .overrunFlag, .noiseFlag, .framingErrorFlag, .parityErrorFlag, .rxWordValid,
  .hostIrq_b, .wakeUp);

// File: testbench/uart_serial_src.sv
// Purpose: serial device model driving the receive line
// Assumes: bitClk is the 16x sample clock
// Notes: bad picks a fault: 1 parity, 2 first stop, 3 noise, 4 last stop
`timescale 1ns/1ps
module uart_serial_src (
  // link
  input wire logic bitClk,
  output logic rxPin
);
  initial rxPin = 1'b1;
  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic podd, input int stops,
    input int bad);
    logic [12:0] f;
    int len;
    f = 13'h1fff;
    len = 1 + n + pen + stops;
    f[0] = 1'b0;
    for (int i = 0; i < n; i++) f[1+i] = d[i];
    if (pen) f[1+n] = ^(d & ((9'h1 << n) - 9'h1)) ^ podd ^ (bad == 1);
    if (bad == 2) f[1+n+pen] = 1'b0;
    if (bad == 4) f[len-1] = 1'b0;
    for (int b = 0; b < len; b++)
      for (int t = 0; t < 16; t++) begin
        @(posedge bitClk);
        rxPin <= f[b] ^ (bad == 3 && b == 1 && t == 8);
      end
    @(posedge bitClk);
    rxPin <= 1'b1;
  endtask
endmodule

// File: testbench/uart_rx_status_tb.sv
// Purpose: self-checking bench of the uart receive status block
// Assumes: mclk 4 ns, bitClk 32 ns
// Notes: expected words kept in a queue
`timescale 1ns/1ps
module uart_rx_status_tb;
  logic mclk, rst_b, rxPin, bitClk, txForceHigh, modulePowerEnable, receiverEnableBit, receiveIrqEnable;
  logic parityEnable, parityOdd, twoStopBits, nineBitSelect, addressDetectEnable, wakeEnable;
  logic txEmptyIrqEnable, txIdleIrqEnable, txEmptyFlag, txIdleFlag, statusAccess, fifoRead;
  logic receiverIdleFlag, receiveDataFlag, overrunFlag, noiseFlag, framingErrorFlag, parityErrorFlag;
  logic rxWordValid, hostIrq_b, wakeUp, expRdf, expOvr, expNf, irqPrev;
  logic [8:0] rxWord;
  logic [10:0] q[$];
  int bad_count, compares, irqs, wakes, cyc, mark;
  uart_serial_src src (.bitClk, .rxPin);
  uart_rx_status dut (.mclk, .rst_b, .rxPin, .bitClk, .txForceHigh, .modulePowerEnable, .receiverEnableBit,
    .receiveIrqEnable, .parityEnable, .parityOdd, .twoStopBits, .nineBitSelect, .addressDetectEnable,
    .wakeEnable, .txEmptyIrqEnable, .txIdleIrqEnable, .txEmptyFlag, .txIdleFlag, .statusAccess, .fifoRead,
    .receiverIdleFlag, .receiveDataFlag, .overrunFlag, .noiseFlag, .framingErrorFlag, .parityErrorFlag,
    .rxWord, .rxWordValid, .hostIrq_b, .wakeUp);
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  initial begin
    bitClk = 0;
    #1.3;
    forever #16 bitClk = ~bitClk;
  end
  task automatic wrap_up();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    irqPrev <= hostIrq_b;
    if (irqPrev === 1'b1 && hostIrq_b === 1'b0) irqs++;
    if (wakeUp === 1'b1) wakes++;
    cyc++;
    if (cyc == 70000) begin
      bad_count++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic fl();
    chk("flags", {expRdf, expOvr, expNf, q.size() != 0}, {receiveDataFlag, overrunFlag, noiseFlag, rxWordValid});
  endtask
  task automatic rx(input logic [8:0] d, input int bad);
    int n;
    logic full;
    logic [10:0] w;
    n = nineBitSelect ? 9 : 8;
    w = {parityEnable & (bad == 1), bad == 2 || bad == 4, n == 9 ? d : {1'b0, d[7:0]}};
    full = q.size() == 4;
    mark = irqs;
    fork
      src.send(d, n, parityEnable, parityOdd, twoStopBits ? 2 : 1, bad);
      begin
        repeat (320) @(negedge mclk);
        chk("idle mid", 11'h0, receiverIdleFlag);
      end
    join
    repeat (20) @(negedge mclk);
    if (!full) begin
      q.push_back(w);
      expRdf = 1;
      expNf |= bad == 3;
    end else expOvr = 1;
    chk("idle end", 11'h1, receiverIdleFlag);
    chk("irqs", receiveIrqEnable && (full || !addressDetectEnable || w[n-1]), 11'(irqs - mark));
    fl();
  endtask
  task automatic rd(input logic arm);
    chk("head", q[0], {parityErrorFlag, framingErrorFlag, rxWord});
    if (arm) begin
      statusAccess = 1;
      @(negedge mclk);
      statusAccess = 0;
    end
    fifoRead = 1;
    @(negedge mclk);
    fifoRead = 0;
    void'(q.pop_front());
    if (arm) begin
      expOvr = 0;
      expNf = 0;
      expRdf = q.size() != 0;
    end
    repeat (4) @(negedge mclk);
    fl();
  endtask
  initial begin
    {rst_b, modulePowerEnable, receiverEnableBit, receiveIrqEnable, parityEnable, parityOdd} = 6'h0;
    {twoStopBits, nineBitSelect, addressDetectEnable, wakeEnable, txEmptyIrqEnable} = 5'h0;
    {txIdleIrqEnable, txEmptyFlag, txIdleFlag, statusAccess, fifoRead, expRdf, expOvr, expNf} = 8'h0;
    void'($urandom(93));
    repeat (16) @(negedge mclk);
    chk("reset", 11'h380, {receiverIdleFlag, txForceHigh, hostIrq_b, receiveDataFlag, overrunFlag, noiseFlag,
      rxWordValid, wakeUp, framingErrorFlag, parityErrorFlag});
    rst_b = 1;
    repeat (4) @(negedge mclk);
    {modulePowerEnable, receiverEnableBit, receiveIrqEnable} = 3'h7;
    for (int i = 0; i < 16; i++) begin
      {twoStopBits, parityOdd, parityEnable, nineBitSelect} = 4'(i);
      rx(9'($urandom()), i == 3 ? 1 : (i == 5 || i == 13) ? 2 : i == 9 ? 3 : i == 10 ? 4 : 0);
      rd(1);
    end
    {twoStopBits, parityOdd, parityEnable, nineBitSelect} = 4'h0;
    repeat (5) rx(9'($urandom()), 0);
    rd(0);
    repeat (3) rd(1);
    addressDetectEnable = 1;
    for (int i = 0; i < 4; i++) begin
      nineBitSelect = i[1];
      rx({i[0] & i[1], i[0] ^ i[1], 7'($urandom())}, 0);
      rd(1);
    end
    {addressDetectEnable, nineBitSelect} = 2'h0;
    for (int i = 0; i < 4; i++) begin
      mark = irqs;
      txEmptyIrqEnable = i[0] | i[1];
      txIdleIrqEnable = i[0] | !i[1];
      if (i[1]) txIdleFlag = 1;
      else txEmptyFlag = 1;
      repeat (30) @(negedge mclk);
      chk("tx irq", 11'(i[0]), 11'(irqs - mark));
      {txEmptyFlag, txIdleFlag, txEmptyIrqEnable, txIdleIrqEnable} = 4'h0;
      repeat (2) @(negedge mclk);
    end
    rx(9'h13c, 0);
    mark = irqs;
    fork
      src.send(9'h0a5, 8, 0, 0, 1, 0);
      begin
        repeat (400) @(negedge mclk);
        modulePowerEnable = 0;
        repeat (4) @(negedge mclk);
        chk("tx high", 11'h1, txForceHigh);
      end
    join
    repeat (40) @(negedge mclk);
    chk("pd irq", 11'h0, 11'(irqs - mark));
    fl();
    {wakeEnable, modulePowerEnable} = 2'h3;
    repeat (4) @(negedge mclk);
    rd(1);
    mark = irqs;
    modulePowerEnable = 0;
    repeat (8) @(negedge mclk);
    fork
      src.send(9'h0ff, 8, 0, 0, 1, 0);
      begin
        for (int t = 0; t < 100 && wakeUp !== 1'b1; t++) @(negedge mclk);
        modulePowerEnable = 1;
      end
    join
    repeat (40) @(negedge mclk);
    chk("wakes", 11'h1, 11'(wakes));
    chk("wake irq", 11'h1, 11'(irqs - mark));
    fl();
    rx(9'h0c3, 2);
    rst_b = 0;
    repeat (3) @(negedge mclk);
    chk("mid reset", 11'h0, {framingErrorFlag, parityErrorFlag, rxWordValid, receiveDataFlag});
    rst_b = 1;
    q.delete();
    expRdf = 0;
    repeat (4) @(negedge mclk);
    fl();
    wrap_up();
  end
endmodule
